// ---- isos_top.sv ----
`timescale 1ns/1ns
module isos_top
    import isos_pkg::*;
#(
    parameter int FW = 16 // Width of frequency and setting values
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic srst, // Synchronous reset, active high
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq, // Level interrupt
    // Drive status from the motor control logic, same clock
    input wire logic drive_active,
    input wire logic reverse_rotation,
    input wire logic [FW-1:0] output_freq,
    input wire logic [FW-1:0] command_freq,
    input wire logic power_fail_status,
    input wire logic current_limit_active,
    input wire logic [FW-1:0] brake_duty,
    input wire logic [FW-1:0] brake_duty_limit,
    input wire logic [FW-1:0] thermal_accum,
    input wire logic [FW-1:0] thermal_trip,
    input wire logic panel_mode,
    // Contact pin to contact_common, high when closed
    input wire logic second_function_contact,
    // Primary parameter set
    input wire logic [FW-1:0] pri_accel_time,
    input wire logic [FW-1:0] pri_decel_time,
    input wire logic [FW-1:0] pri_torque_boost,
    input wire logic [FW-1:0] pri_base_frequency,
    input wire logic [FW-1:0] accel_ref_frequency,
    // Selected parameter set
    output logic [FW-1:0] sel_accel_time,
    output logic [FW-1:0] sel_decel_time,
    output logic [FW-1:0] sel_torque_boost,
    output logic [FW-1:0] sel_base_frequency,
    output logic [FW-1:0] sel_ramp_ref_frequency,
    output logic sec_stall_enable,
    output logic [FW-1:0] sec_stall_frequency,
    // Open-collector transistors, high is on
    output logic run_terminal_on,
    output logic up_to_speed_terminal_on,
    output logic power_fail_terminal_on,
    output logic overload_terminal_on,
    output logic freq_detect_terminal_on
);

    // Whole block state, registered in one place
    typedef struct packed {
        logic [15:0] assign_q; // Terminal assignment setting
        logic [15:0] band_q; // Up-to-speed band percent
        logic [15:0] det_pri_q; // Primary detect threshold
        logic [15:0] det_rev_q; // Reverse detect threshold
        logic [15:0] det_sec_q; // Second detect threshold
        logic [15:0] start_q; // Starting frequency
        logic [15:0] sec_acc_q;
        logic [15:0] sec_dec_q;
        logic [15:0] sec_boost_q;
        logic [15:0] sec_base_q;
        logic [15:0] sec_stall_q;
        logic [1:0] contact_sync_q; // Two-stage pin synchroniser
        logic ack_q; // Bus answer cycle
        logic [31:0] rdata_q;
        logic [ISOS_NFUNC-1:0] func_q; // Registered function vector
        logic run_q;
        logic [ISOS_NTERM-1:0] term_q; // Assignable terminals
        logic [ISOS_NEV-1:0] ev_prev_q;
        logic [ISOS_NEV-1:0] irq_stat_q;
        logic [ISOS_NEV-1:0] irq_mask_q;
    } isos_state_t;

    isos_state_t s_q;
    isos_state_t s_d;

    // True when a reaches pct percent of b; wide math avoids overflow
    function automatic logic isos_reached(input logic [15:0] a, input logic [15:0] b,
                                          input logic [15:0] pct);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = {16'h0000, a} * {16'h0000, ISOS_FULL_PCT};
        rhs = {16'h0000, b} * {16'h0000, pct};
        return lhs >= rhs;
    endfunction : isos_reached

    // Pick one function by its code; undefined codes give off
    function automatic logic isos_pick(input logic [3:0] code,
                                       input logic [ISOS_NFUNC-1:0] f);
        logic r;
        r = 1'b0;
        if (code <= ISOS_CODE_MAX && code != ISOS_CODE_UNDEF) begin // [R18]
            r = f[code];
        end
        return r;
    endfunction : isos_pick

    // Byte-lane merge for register writes
    function automatic logic [15:0] isos_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : isos_merge

    logic contact_closed; // Synchronised contact level
    logic [15:0] fout;
    logic [15:0] fcmd;
    logic [15:0] diff; // Distance from commanded frequency
    logic [15:0] band_eff; // Band clamped to its legal range
    logic [15:0] thr; // Active detect threshold
    logic [ISOS_NFUNC-1:0] func; // Status by function code
    logic [ISOS_NEV-1:0] ev_lvl; // Levels that raise interrupts
    logic [31:0] rd; // Read mux
    logic req;
    logic take; // Edge at which the access completes

    assign fout = 16'(output_freq);
    assign fcmd = 16'(command_freq);
    assign contact_closed = s_q.contact_sync_q[1];
    assign req = avs_read | avs_write;
    assign take = req & s_q.ack_q;

    // Status condition logic
    always_comb begin
        diff = (fout >= fcmd) ? (fout - fcmd) : (fcmd - fout);
        band_eff = s_q.band_q;
        if (band_eff < ISOS_BAND_MIN) begin
            band_eff = ISOS_BAND_MIN;
        end else if (band_eff > ISOS_BAND_MAX) begin
            band_eff = ISOS_BAND_MAX;
        end
        // Unset reverse threshold means primary for both directions
        if (reverse_rotation && s_q.det_rev_q != ISOS_UNSET) begin // [R13]
            thr = s_q.det_rev_q;
        end else begin
            thr = s_q.det_pri_q;
        end
        func = '0;
        func[0] = drive_active & (fout >= s_q.start_q); // [R2]
        func[1] = drive_active & isos_reached(fcmd - ((fcmd >= diff) ? diff : fcmd),
                  fcmd, ISOS_FULL_PCT - band_eff); // [R3]
        func[2] = power_fail_status; // [R4]
        func[3] = current_limit_active; // [R5]
        func[4] = fout >= thr; // [R6] [R12]
        func[5] = fout >= s_q.det_sec_q; // [R6]
        func[6] = isos_reached(16'(brake_duty), 16'(brake_duty_limit),
                               ISOS_PREALARM_PCT); // [R7]
        func[7] = isos_reached(16'(thermal_accum), 16'(thermal_trip),
                               ISOS_PREALARM_PCT); // [R8]
        func[9] = panel_mode; // [R9]
        ev_lvl = '0;
        ev_lvl[ISOS_EV_PF] = func[2];
        ev_lvl[ISOS_EV_OL] = func[3];
        ev_lvl[ISOS_EV_RBP] = func[6];
        ev_lvl[ISOS_EV_THP] = func[7];
    end

    // Read data mux; unmapped reads return zero
    always_comb begin
        rd = 32'h0000_0000;
        case (avs_address)
            ISOS_ASSIGN: rd[15:0] = s_q.assign_q;
            ISOS_BAND: rd[15:0] = s_q.band_q;
            ISOS_DET_PRI: rd[15:0] = s_q.det_pri_q;
            ISOS_DET_REV: rd[15:0] = s_q.det_rev_q;
            ISOS_DET_SEC: rd[15:0] = s_q.det_sec_q;
            ISOS_START: rd[15:0] = s_q.start_q;
            ISOS_SEC_ACC: rd[15:0] = s_q.sec_acc_q;
            ISOS_SEC_DEC: rd[15:0] = s_q.sec_dec_q;
            ISOS_SEC_BOOST: rd[15:0] = s_q.sec_boost_q;
            ISOS_SEC_BASE: rd[15:0] = s_q.sec_base_q;
            ISOS_SEC_STALL: rd[15:0] = s_q.sec_stall_q;
            ISOS_STATUS: rd[15:0] = {contact_closed, s_q.run_q, s_q.term_q, s_q.func_q};
            ISOS_IRQ_STAT: rd[ISOS_NEV-1:0] = s_q.irq_stat_q;
            ISOS_IRQ_MASK: rd[ISOS_NEV-1:0] = s_q.irq_mask_q;
            default: rd = 32'h0000_0000;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        // Only the second stage is read by logic
        s_d.contact_sync_q = {s_q.contact_sync_q[0], second_function_contact};
        // One wait cycle, then the access completes
        s_d.ack_q = req & ~s_q.ack_q;
        if (req && !s_q.ack_q) begin
            s_d.rdata_q = avs_read ? rd : 32'h0000_0000;
        end
        s_d.func_q = func;
        s_d.run_q = func[0]; // [R11]
        // Each terminal follows the code in its digit
        for (int t = 0; t < ISOS_NTERM; t++) begin
            s_d.term_q[t] = isos_pick(s_q.assign_q[15 - t*ISOS_DIGIT_W -: ISOS_DIGIT_W],
                                      func); // [R1]
        end
        s_d.ev_prev_q = ev_lvl;
        // Rising edges set sticky bits; set beats a same-cycle clear
        if (take && avs_write && avs_address == ISOS_IRQ_STAT && avs_byteenable[0]) begin
            s_d.irq_stat_q = s_q.irq_stat_q & ~avs_writedata[ISOS_NEV-1:0];
        end
        s_d.irq_stat_q = s_d.irq_stat_q | (ev_lvl & ~s_q.ev_prev_q);
        // Register writes take effect at the completing edge
        if (take && avs_write) begin
            case (avs_address)
                ISOS_ASSIGN: s_d.assign_q = isos_merge(s_q.assign_q, avs_writedata,
                                                       avs_byteenable); // [R1]
                ISOS_BAND: s_d.band_q = isos_merge(s_q.band_q, avs_writedata,
                                                   avs_byteenable);
                ISOS_DET_PRI: s_d.det_pri_q = isos_merge(s_q.det_pri_q, avs_writedata,
                                                         avs_byteenable);
                ISOS_DET_REV: s_d.det_rev_q = isos_merge(s_q.det_rev_q, avs_writedata,
                                                         avs_byteenable);
                ISOS_DET_SEC: s_d.det_sec_q = isos_merge(s_q.det_sec_q, avs_writedata,
                                                         avs_byteenable);
                ISOS_START: s_d.start_q = isos_merge(s_q.start_q, avs_writedata,
                                                     avs_byteenable);
                ISOS_SEC_ACC: s_d.sec_acc_q = isos_merge(s_q.sec_acc_q, avs_writedata,
                                                         avs_byteenable);
                ISOS_SEC_DEC: s_d.sec_dec_q = isos_merge(s_q.sec_dec_q, avs_writedata,
                                                         avs_byteenable);
                ISOS_SEC_BOOST: s_d.sec_boost_q = isos_merge(s_q.sec_boost_q,
                                                             avs_writedata, avs_byteenable);
                ISOS_SEC_BASE: s_d.sec_base_q = isos_merge(s_q.sec_base_q, avs_writedata,
                                                           avs_byteenable);
                ISOS_SEC_STALL: s_d.sec_stall_q = isos_merge(s_q.sec_stall_q,
                                                             avs_writedata, avs_byteenable);
                ISOS_IRQ_MASK: begin
                    if (avs_byteenable[0]) begin
                        s_d.irq_mask_q = avs_writedata[ISOS_NEV-1:0];
                    end
                end
                default: ; // Status read-only, IRQ status cleared above, unmapped: write ignored
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
            s_q.assign_q <= ISOS_ASSIGN_RST; // [R1]
            s_q.band_q <= ISOS_BAND_RST;
            s_q.det_pri_q <= ISOS_DET_PRI_RST;
            s_q.det_rev_q <= ISOS_UNSET; // [R13]
            s_q.det_sec_q <= ISOS_DET_SEC_RST;
            s_q.start_q <= ISOS_START_RST;
            s_q.sec_acc_q <= ISOS_SEC_ACC_RST;
            s_q.sec_dec_q <= ISOS_UNSET; // [R15]
            s_q.sec_boost_q <= ISOS_SEC_BOOST_RST;
            s_q.sec_base_q <= ISOS_SEC_BASE_RST;
            s_q.sec_stall_q <= ISOS_ZERO; // [R17]
        end else begin
            s_q <= s_d;
        end
    end

    // Bus handshake and read data
    assign avs_waitrequest = req & ~s_q.ack_q;
    assign avs_readdata = s_q.rdata_q;
    assign irq = |(s_q.irq_stat_q & s_q.irq_mask_q);

    // Transistor on for an asserted status; on drives the pin low
    assign run_terminal_on = s_q.run_q; // [R10] [R11]
    assign up_to_speed_terminal_on = s_q.term_q[0]; // [R10]
    assign power_fail_terminal_on = s_q.term_q[1]; // [R10]
    assign overload_terminal_on = s_q.term_q[2]; // [R10]
    assign freq_detect_terminal_on = s_q.term_q[3]; // [R10] [R12]

    // Parameter set selection by the external contact
    always_comb begin
        if (contact_closed) begin // [R14]
            sel_accel_time = FW'(s_q.sec_acc_q);
            // Unset secondary decel reuses the secondary accel time
            sel_decel_time = (s_q.sec_dec_q == ISOS_UNSET) ? FW'(s_q.sec_acc_q)
                                                           : FW'(s_q.sec_dec_q); // [R15]
            sel_torque_boost = FW'(s_q.sec_boost_q);
            sel_base_frequency = FW'(s_q.sec_base_q);
        end else begin
            sel_accel_time = pri_accel_time;
            sel_decel_time = pri_decel_time;
            sel_torque_boost = pri_torque_boost;
            sel_base_frequency = pri_base_frequency;
        end
    end

    // Both ramp sets are scaled against the same reference frequency
    assign sel_ramp_ref_frequency = accel_ref_frequency; // [R16]
    assign sec_stall_enable = s_q.sec_stall_q != ISOS_ZERO; // [R17]
    assign sec_stall_frequency = FW'(s_q.sec_stall_q);

endmodule : isos_top

// ---- isos_pkg.sv ----
// Function
// R1: Four digits pick each terminal's function
// R2: Code 0 on at or above start frequency
// R3: Code 1 inside percentage band of command
// R4: Code 2 on supply dip or undervoltage
// R5: Code 3 while current limiting acts
// R6: Codes 4, 5 at or above thresholds
// R7: Code 6 at 85% brake duty
// R8: Code 7 at 85% thermal trip
// R9: Code 9 during panel operation
// R10: Asserted status turns transistor on
// R11: Running terminal fixed to running function
// R12: Detect pin low at or above threshold
// R13: Reverse threshold used only in reverse
// R14: Contact closed selects secondary parameter set
// R15: Decel 9999 reuses secondary acceleration time
// R16: Secondary ramps share acceleration reference frequency
// R17: Secondary stall frequency zero disables it
// R18: Undefined code keeps terminal off
package isos_pkg;
    // Register byte offsets
    localparam logic [7:0] ISOS_ASSIGN = 8'h00;
    localparam logic [7:0] ISOS_BAND = 8'h04;
    localparam logic [7:0] ISOS_DET_PRI = 8'h08;
    localparam logic [7:0] ISOS_DET_REV = 8'h0c;
    localparam logic [7:0] ISOS_DET_SEC = 8'h10;
    localparam logic [7:0] ISOS_START = 8'h14;
    localparam logic [7:0] ISOS_SEC_ACC = 8'h18;
    localparam logic [7:0] ISOS_SEC_DEC = 8'h1c;
    localparam logic [7:0] ISOS_SEC_BOOST = 8'h20;
    localparam logic [7:0] ISOS_SEC_BASE = 8'h24;
    localparam logic [7:0] ISOS_SEC_STALL = 8'h28;
    localparam logic [7:0] ISOS_STATUS = 8'h2c;
    localparam logic [7:0] ISOS_IRQ_STAT = 8'h30;
    localparam logic [7:0] ISOS_IRQ_MASK = 8'h34;
    // Reset values
    localparam logic [15:0] ISOS_ASSIGN_RST = 16'h1234;
    localparam logic [15:0] ISOS_BAND_RST = 16'h000a;
    localparam logic [15:0] ISOS_DET_PRI_RST = 16'h1770;
    localparam logic [15:0] ISOS_DET_SEC_RST = 16'h0bb8;
    localparam logic [15:0] ISOS_START_RST = 16'h0032;
    localparam logic [15:0] ISOS_UNSET = 16'h270f;
    localparam logic [15:0] ISOS_SEC_ACC_RST = 16'h01f4;
    localparam logic [15:0] ISOS_SEC_BOOST_RST = 16'h0006;
    localparam logic [15:0] ISOS_SEC_BASE_RST = 16'h1770;
    localparam logic [15:0] ISOS_ZERO = 16'h0000;
    // Band limits and prealarm percentage
    localparam logic [15:0] ISOS_BAND_MIN = 16'h0001;
    localparam logic [15:0] ISOS_BAND_MAX = 16'h0064;
    localparam logic [15:0] ISOS_PREALARM_PCT = 16'h0055;
    localparam logic [15:0] ISOS_FULL_PCT = 16'h0064;
    // Function codes
    localparam logic [3:0] ISOS_CODE_UNDEF = 4'h8;
    localparam logic [3:0] ISOS_CODE_MAX = 4'h9;
    // Digit field positions, first digit highest
    localparam int ISOS_DIGIT_W = 4;
    localparam int ISOS_NTERM = 4;
    localparam int ISOS_NFUNC = 10;
    // Interrupt bit positions
    localparam int ISOS_EV_PF = 0;
    localparam int ISOS_EV_OL = 1;
    localparam int ISOS_EV_RBP = 2;
    localparam int ISOS_EV_THP = 3;
    localparam int ISOS_NEV = 4;
endpackage : isos_pkg

// ---- isos_top_assertions.sv ----
`timescale 1ns/1ns
// Port checks; terminal map shadowed from bus writes
module isos_top_assertions
    import isos_pkg::*;
#(
    parameter int FW = 16 // Width of frequency and setting values
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic drive_active,
    input wire logic power_fail_status,
    input wire logic current_limit_active,
    input wire logic second_function_contact,
    input wire logic [FW-1:0] pri_accel_time,
    input wire logic [FW-1:0] pri_decel_time,
    input wire logic [FW-1:0] pri_torque_boost,
    input wire logic [FW-1:0] pri_base_frequency,
    input wire logic [FW-1:0] accel_ref_frequency,
    input wire logic [FW-1:0] sel_accel_time,
    input wire logic [FW-1:0] sel_decel_time,
    input wire logic [FW-1:0] sel_torque_boost,
    input wire logic [FW-1:0] sel_base_frequency,
    input wire logic [FW-1:0] sel_ramp_ref_frequency,
    input wire logic sec_stall_enable,
    input wire logic [FW-1:0] sec_stall_frequency,
    input wire logic run_terminal_on,
    input wire logic up_to_speed_terminal_on,
    input wire logic power_fail_terminal_on,
    input wire logic overload_terminal_on
);
    typedef struct packed {
        logic [15:0] amap; // Shadow of the assignment digits
    } isos_chk_t;
    isos_chk_t st_q; // Registered shadow state
    isos_chk_t st_d; // Next shadow state
    logic map_wr; // Write to the assignment completes this edge
    logic [3:0] d0; // Digit of the up-to-speed terminal
    assign map_wr = avs_write && !avs_waitrequest && avs_address == ISOS_ASSIGN;
    assign d0 = st_q.amap[15:12];
    always_comb begin
        st_d = st_q;
        if (map_wr && avs_byteenable[0]) begin
            st_d.amap[7:0] = avs_writedata[7:0];
        end
        if (map_wr && avs_byteenable[1]) begin
            st_d.amap[15:8] = avs_writedata[15:8];
        end
    end
    // Reset restores the default map
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '{amap: ISOS_ASSIGN_RST};
        end else begin
            st_q <= st_d;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Contact open through the synchroniser
    sequence s_open3;
        !second_function_contact [*3];
    endsequence
    // First cycle of a bus request
    sequence s_req_new;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    a_run_idle_off: assert property (!drive_active |=> !run_terminal_on)
        else $error("run terminal on while drive idle");
    a_pf_follows: assert property (st_q.amap[11:8] == 4'h2
        |=> power_fail_terminal_on == $past(power_fail_status))
        else $error("power fail terminal wrong");
    a_ol_follows: assert property (st_q.amap[7:4] == 4'h3
        |=> overload_terminal_on == $past(current_limit_active))
        else $error("overload terminal wrong");
    a_undef_off: assert property (d0 == ISOS_CODE_UNDEF || d0 > ISOS_CODE_MAX
        |=> !up_to_speed_terminal_on)
        else $error("undefined code drives terminal");
    a_bus_one_wait: assert property (s_req_new |=> !avs_waitrequest)
        else $error("bus answer late");
    a_sel_primary: assert property (s_open3 |-> sel_accel_time == pri_accel_time
        && sel_decel_time == pri_decel_time && sel_torque_boost == pri_torque_boost
        && sel_base_frequency == pri_base_frequency)
        else $error("primary set not selected");
    a_ramp_ref: assert property (sel_ramp_ref_frequency == accel_ref_frequency)
        else $error("ramp reference differs");
    a_stall_zero: assert property (sec_stall_enable == (sec_stall_frequency != '0))
        else $error("stall enable wrong");
endmodule : isos_top_assertions
bind isos_top isos_top_assertions #(.FW(FW)) i_isos_top_assertions (.*);

// ---- isos_plant.sv ----
`timescale 1ns/1ns
// Plant: pull-ups on the open-collector pins, and the contact
module isos_plant (
    input wire logic [4:0] tr_on, // Transistors, high conducts
    input wire logic close_req, // Contact closing asked by the bench
    output logic [4:0] pin_lvl, // Levels seen by the relay logic
    output logic second_function_contact // High while closed
);
    // A conducting transistor pulls the pin low
    assign pin_lvl = ~tr_on;
    // Dry contact to contact_common, no bounce modelled
    assign second_function_contact = close_req;
endmodule : isos_plant

// ---- tb_inverter_status_output_select.sv ----
`timescale 1ns/1ns
module tb_inverter_status_output_select
    import isos_pkg::*;
;
    logic clk_sys = 0;
    logic srst = 1;
    logic [7:0] avs_address = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [4:0] ins = 0; // drive, reverse, power fail, limit, panel
    logic [15:0] fo = 0, fcm = 0, bd = 0, ta = 0;
    logic [15:0] pri_accel_time = 0, pri_decel_time = 0, pri_torque_boost = 0;
    logic [15:0] pri_base_frequency = 0, accel_ref_frequency = 0;
    logic [15:0] sel_accel_time, sel_decel_time, sel_torque_boost, sel_base_frequency;
    logic [15:0] sel_ramp_ref_frequency, sec_stall_frequency;
    logic sec_stall_enable, contact, close = 0, smp = 0;
    logic [4:0] ton, pin; // run, up-to-speed, power fail, overload, detect
    logic [15:0] amap = ISOS_ASSIGN_RST; // Map the bench expects
    logic [15:0] thr_r = ISOS_UNSET; // Reverse threshold the bench expects
    logic [31:0] q_rd[$], q_pin[$]; // Expected read data and pin levels
    logic [15:0] bases [8] = '{16'd49, 16'd50, 16'd999, 16'd1000, 16'd2999, 16'd3000,
        16'd5999, 16'd6000}; // Both sides of each threshold
    logic [7:0] ra [7] = '{ISOS_ASSIGN, ISOS_BAND, ISOS_DET_PRI, ISOS_DET_REV,
        ISOS_SEC_DEC, ISOS_SEC_STALL, 8'h3c};
    logic [15:0] rv [7] = '{ISOS_ASSIGN_RST, ISOS_BAND_RST, ISOS_DET_PRI_RST, ISOS_UNSET,
        ISOS_UNSET, ISOS_ZERO, ISOS_ZERO};
    int n_fail = 0, tests_run = 0, seed = 7;
    isos_top i_isos_top (.clk_sys, .srst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq,
        .drive_active(ins[4]), .reverse_rotation(ins[3]), .output_freq(fo),
        .command_freq(fcm), .power_fail_status(ins[2]), .current_limit_active(ins[1]),
        .brake_duty(bd), .brake_duty_limit(16'd200), .thermal_accum(ta),
        .thermal_trip(16'd100), .panel_mode(ins[0]), .second_function_contact(contact),
        .pri_accel_time, .pri_decel_time, .pri_torque_boost, .pri_base_frequency,
        .accel_ref_frequency, .sel_accel_time, .sel_decel_time, .sel_torque_boost,
        .sel_base_frequency, .sel_ramp_ref_frequency, .sec_stall_enable,
        .sec_stall_frequency, .run_terminal_on(ton[4]), .up_to_speed_terminal_on(ton[3]),
        .power_fail_terminal_on(ton[2]), .overload_terminal_on(ton[1]),
        .freq_detect_terminal_on(ton[0]));
    isos_plant i_isos_plant (.tr_on(ton), .close_req(close), .pin_lvl(pin),
        .second_function_contact(contact));
    // 100 MHz clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Counts and reports one comparison
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic results();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // One bus cycle held until waitrequest low, then an idle edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk_sys);
    endtask : bus
    // Read with its expected value noted first
    task automatic rdq(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(0, a, 0);
    endtask : rdq
    // Expected level of one function code
    function automatic logic fn(input logic [3:0] c);
        int d;
        d = (fo > fcm) ? int'(fo - fcm) : int'(fcm - fo);
        case (c)
            4'h0: return ins[4] && fo >= ISOS_START_RST;
            4'h1: return ins[4] && d <= int'(fcm) * int'(ISOS_BAND_RST) / 100;
            4'h2: return ins[2];
            4'h3: return ins[1];
            4'h4: return fo >= ((ins[3] && thr_r != ISOS_UNSET) ? thr_r : ISOS_DET_PRI_RST);
            4'h5: return fo >= ISOS_DET_SEC_RST;
            4'h6: return 32'(bd) * ISOS_FULL_PCT >= 32'd200 * ISOS_PREALARM_PCT;
            4'h7: return 32'(ta) * ISOS_FULL_PCT >= 32'd100 * ISOS_PREALARM_PCT;
            4'h9: return ins[0];
            default: return 1'b0;
        endcase
    endfunction : fn
    // Random cycles across thresholds
    task automatic step(input int n);
        logic [31:0] v;
        repeat (n) begin
            v = $random(seed);
            ins <= v[4:0];
            fo <= bases[v[7:5]];
            fcm <= bases[v[7:5]] + 16'(v[10:8]) * 16'd100;
            bd <= 16'd160 + 16'(v[15:11]);
            ta <= 16'd80 + 16'(v[19:16]);
            @(posedge clk_sys);
            q_pin.push_back({27'h0, ~{fn(4'h0), fn(amap[15:12]), fn(amap[11:8]),
                fn(amap[7:4]), fn(amap[3:0])}});
            smp <= 1;
            @(posedge clk_sys);
            smp <= 0;
        end
    endtask : step
    // Bounded wait for an interrupt level
    task automatic irq_is(input logic e);
        int k;
        for (k = 0; k < 8 && irq !== e; k++) begin
            @(posedge clk_sys);
        end
        chk(irq, e);
    endtask : irq_is
    // Monitor: compare at read completion and pin samples
    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            chk(avs_readdata, q_rd.pop_front());
        end
        if (smp) begin
            chk({27'h0, pin}, q_pin.pop_front());
        end
    end
    // Watchdog, well past the run
    initial begin
        #400000;
        n_fail++;
        results();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 0;
        repeat (2) @(posedge clk_sys);
        foreach (ra[i]) rdq(ra[i], {16'h0, rv[i]});
        step(40);
        // One code on all four assignable terminals, undefined ones too
        for (int c = 0; c < 16; c++) begin
            amap = {4{4'(c)}};
            bus(1, ISOS_ASSIGN, {16'h0, amap});
            step(12);
        end
        amap = 16'h3249;
        bus(1, ISOS_ASSIGN, {16'h0, amap});
        step(20);
        // Separate reverse threshold
        thr_r = 16'd1000;
        bus(1, ISOS_DET_REV, {16'h0, thr_r});
        amap = 16'h4444;
        bus(1, ISOS_ASSIGN, {16'h0, amap});
        step(40);
        // Second set via contact; decel follows accel
        {pri_accel_time, pri_decel_time} <= $random(seed);
        {pri_torque_boost, pri_base_frequency} <= $random(seed);
        accel_ref_frequency <= 16'h0bb8;
        close <= 1;
        repeat (3) @(posedge clk_sys);
        chk(sel_accel_time, ISOS_SEC_ACC_RST);
        chk(sel_decel_time, ISOS_SEC_ACC_RST);
        chk(sel_torque_boost, ISOS_SEC_BOOST_RST);
        chk(sel_base_frequency, ISOS_SEC_BASE_RST);
        chk(sel_ramp_ref_frequency, 16'h0bb8);
        bus(1, ISOS_SEC_DEC, 32'h2bc);
        chk(sel_decel_time, 16'h2bc);
        bus(1, ISOS_SEC_STALL, 32'h5);
        chk({sec_stall_enable, sec_stall_frequency}, 17'h10005);
        close <= 0;
        repeat (3) @(posedge clk_sys);
        chk({sel_accel_time, sel_decel_time}, {pri_accel_time, pri_decel_time});
        // Interrupt raised, masked and cleared
        ins <= 5'h0;
        bd <= 0;
        ta <= 0;
        bus(1, ISOS_IRQ_STAT, 32'hf);
        bus(1, ISOS_IRQ_MASK, 32'h1);
        ins <= 5'h06;
        irq_is(1);
        rdq(ISOS_IRQ_STAT, 32'h3);
        bus(1, ISOS_IRQ_STAT, 32'h1);
        irq_is(0);
        bus(1, ISOS_IRQ_MASK, 32'h2);
        irq_is(1);
        bus(1, ISOS_IRQ_STAT, 32'h2);
        irq_is(0);
        results();
    end
endmodule : tb_inverter_status_output_select
